// ### hall_commutation_decoder.sv
// Purpose: Rotor position decoder and six step commutation sequencer.
// Assumes: Sensor, jumper, direction, enable and undervoltage pins are
//          asynchronous and pass a two stage synchroniser.
// Notes: Drive outputs are active high (switch on) and registered.
// Behaviour
// (R1) One top, one bottom, different legs.
// (R2) Sensors change code every 60 degrees.
// (R3) Sixty degree code order accepted.
// (R4) One twenty degree code order accepted.
// (R5) Three hundred degree motor runs reversed.
// (R6) Two forty degree motor runs reversed.
// (R7) Phasing jumper selects decoding table.
// (R8) Output enable low forces tops off.
// (R9) Invalid sensor code asserts fault.
// (R10) Output enable low asserts fault.
// (R11) Direction one forward, zero reverse.
// (R12) Undervoltage: fault, tops off, bottoms low.
// (R13) Invalid code turns all drives off.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module hall_commutation_decoder #(
    parameter int ADDR_BITS = hall_commutation_pkg::ADDR_W,
    parameter int SYNC_DEPTH = hall_commutation_pkg::SYNC_STAGES
) (
    // Clock, reset and enable
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Rotor sensors and pin controls
    input wire logic i_rotor_sensor_a,
    input wire logic i_rotor_sensor_b,
    input wire logic i_rotor_sensor_c,
    input wire logic i_phasing_jumper,
    input wire logic i_direction,
    input wire logic i_output_enable,
    input wire logic i_undervoltage,
    // Register port
    input wire logic [ADDR_BITS-1:0] i_addr,
    input wire logic [hall_commutation_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [hall_commutation_pkg::DATA_W-1:0] o_rdata,
    // Drives, fault and interrupt
    output logic [2:0] o_top_drive,
    output logic [2:0] o_bottom_drive,
    output logic o_fault_n,
    output logic o_irq
);
    import hall_commutation_pkg::*;

    // Elaboration checks on parameters the logic cannot serve.
    generate
        if (SYNC_DEPTH < 2) begin : g_bad_sync
            $error("SYNC_DEPTH must be at least 2");
        end
        if (ADDR_BITS < 5 || ADDR_BITS > 8) begin : g_bad_addr
            $error("ADDR_BITS must lie between 5 and 8");
        end
    endgenerate

    // Pin synchronisers: seven asynchronous inputs, one chain each.
    localparam int PINS = 7;
    logic [PINS-1:0] pin_raw;
    logic [PINS-1:0] pin_sync;

    assign pin_raw = {i_undervoltage, i_output_enable, i_direction,
                      i_phasing_jumper, i_rotor_sensor_a,
                      i_rotor_sensor_b, i_rotor_sensor_c};

    genvar p;
    generate
        for (p = 0; p < PINS; p++) begin : g_sync
            logic [SYNC_DEPTH-1:0] chain;
            always_ff @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    chain <= '0;
                end else if (i_ce) begin
                    chain <= {chain[SYNC_DEPTH-2:0], pin_raw[p]};
                end
            end
            assign pin_sync[p] = chain[SYNC_DEPTH-1];
        end
    endgenerate

    // Named views of the synchronised pins.
    logic [2:0] sensor_code;
    logic jumper_open;
    logic dir_pin;
    logic oe_pin;
    logic uv_pin;

    assign sensor_code = pin_sync[2:0];
    assign jumper_open = pin_sync[3];
    assign dir_pin = pin_sync[4];
    assign oe_pin = pin_sync[5];
    assign uv_pin = pin_sync[6];

    // Software registers.
    logic [CTRL_W-1:0] control;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;

    // Jumper tied low selects the 120/240 table; open selects 60/300.
    logic sel_120;
    assign sel_120 = ~jumper_open; // (R7)

    // Position decode.
    logic code_valid;
    logic [2:0] position;

    hall_position_lookup u_lookup (
        .i_code(sensor_code),
        .i_sel_120(sel_120),
        .o_valid(code_valid),
        .o_index(position)
    );

    // Leg lookup and one hot expansion, shared by top and bottom paths.
    function automatic logic [1:0] leg_of(input logic [11:0] legs,
                                          input logic [2:0] idx);
        leg_of = legs[2*idx +: 2];
    endfunction : leg_of

    function automatic logic [2:0] leg_mask(input logic [1:0] leg);
        leg_mask = 3'h1 << leg;
    endfunction : leg_mask

    // Reverse drive swaps the top and bottom legs of each position, so
    // a reversed code sequence (300 or 240 degree motor) also turns the
    // rotor, only the other way round.
    logic forward;
    logic [1:0] fwd_top_leg;
    logic [1:0] fwd_bottom_leg;
    logic [1:0] top_leg;
    logic [1:0] bottom_leg;

    assign forward = dir_pin ^ control[CTRL_DIR_INVERT_BIT]; // (R11)
    assign fwd_top_leg = leg_of(FWD_TOP_LEGS, position);
    assign fwd_bottom_leg = leg_of(FWD_BOTTOM_LEGS, position);
    assign top_leg = forward ? fwd_top_leg : fwd_bottom_leg; // (R11) (R5) (R6)
    assign bottom_leg = forward ? fwd_bottom_leg : fwd_top_leg; // (R11)

    // Gating of the drive pattern.
    logic oe_eff;
    logic tops_allowed;
    logic bottoms_allowed;
    logic [2:0] next_top;
    logic [2:0] next_bottom;
    logic next_fault;

    assign oe_eff = oe_pin & control[CTRL_SOFT_ENABLE_BIT];
    assign bottoms_allowed = code_valid & ~uv_pin; // (R12) (R13)
    assign tops_allowed = bottoms_allowed & oe_eff; // (R8)
    assign next_top = tops_allowed ? leg_mask(top_leg) : 3'h0; // (R1)
    assign next_bottom = bottoms_allowed ? leg_mask(bottom_leg) : 3'h0; // (R1)
    assign next_fault = ~code_valid | ~oe_eff | uv_pin; // (R9) (R10) (R12)

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_top_drive <= 3'h0;
            o_bottom_drive <= 3'h0;
            o_fault_n <= 1'b0;
        end else if (i_ce) begin
            o_top_drive <= next_top;
            o_bottom_drive <= next_bottom;
            o_fault_n <= ~next_fault;
        end
    end

    // Event detection against the previous decoded state.
    logic prev_valid;
    logic [2:0] prev_position;
    logic prev_fault;
    logic prev_uv;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_valid <= 1'b0;
            prev_position <= 3'h0;
            prev_fault <= 1'b1;
            prev_uv <= 1'b0;
        end else if (i_ce) begin
            prev_valid <= code_valid;
            prev_position <= position;
            prev_fault <= next_fault;
            prev_uv <= uv_pin;
        end
    end

    // The step event expects one position change per 60 degrees; a code
    // jump of several positions still raises a single step event.
    logic [IRQ_W-1:0] irq_event;
    assign irq_event[IRQ_STEP_BIT] = code_valid & prev_valid &
                                     (position != prev_position); // (R2)
    assign irq_event[IRQ_INVALID_BIT] = ~code_valid & prev_valid; // (R9)
    assign irq_event[IRQ_FAULT_BIT] = next_fault & ~prev_fault;
    assign irq_event[IRQ_UNDERVOLT_BIT] = uv_pin & ~prev_uv; // (R12)

    // Register decode.
    logic hit_control;
    logic hit_enable;
    logic hit_clear;
    logic wr_control;
    logic wr_enable;
    logic wr_clear;

    assign hit_control = (i_addr == REG_CONTROL[ADDR_BITS-1:0]);
    assign hit_enable = (i_addr == REG_IRQ_ENABLE[ADDR_BITS-1:0]);
    assign hit_clear = (i_addr == REG_IRQ_CLEAR[ADDR_BITS-1:0]);
    assign wr_control = i_wr & hit_control;
    assign wr_enable = i_wr & hit_enable;
    assign wr_clear = i_wr & hit_clear;

    // A new event wins over a clear written in the same cycle.
    logic [IRQ_W-1:0] clear_bits;
    logic [IRQ_W-1:0] next_irq_status;
    assign clear_bits = wr_clear ? i_wdata[IRQ_W-1:0] : '0;
    assign next_irq_status = (irq_status & ~clear_bits) | irq_event;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            control <= CONTROL_RESET;
            irq_enable <= IRQ_ENABLE_RESET;
            irq_status <= '0;
        end else if (i_ce) begin
            if (wr_control) begin
                control <= i_wdata[CTRL_W-1:0];
            end
            if (wr_enable) begin
                irq_enable <= i_wdata[IRQ_W-1:0];
            end
            irq_status <= next_irq_status;
        end
    end

    assign o_irq = |(irq_status & irq_enable);

    // Read path: state word built from live decoder state.
    logic [DATA_W-1:0] state_word;
    logic [DATA_W-1:0] read_mux;

    always_comb begin
        state_word = '0;
        state_word[ST_CODE_LSB +: 3] = sensor_code;
        state_word[ST_INDEX_LSB +: 3] = position;
        state_word[ST_VALID_BIT] = code_valid;
        state_word[ST_FAULT_BIT] = ~o_fault_n;
        state_word[ST_TOP_LSB +: 3] = o_top_drive;
        state_word[ST_BOTTOM_LSB +: 3] = o_bottom_drive;
        state_word[ST_SEL120_BIT] = sel_120;
        state_word[ST_FORWARD_BIT] = forward;
    end

    // Unmapped and write-only addresses read as zero.
    always_comb begin
        read_mux = '0;
        if (i_addr == REG_CONTROL[ADDR_BITS-1:0]) begin
            read_mux[CTRL_W-1:0] = control;
        end else if (i_addr == REG_STATE[ADDR_BITS-1:0]) begin
            read_mux = state_word;
        end else if (i_addr == REG_IRQ_STATUS[ADDR_BITS-1:0]) begin
            read_mux[IRQ_W-1:0] = irq_status;
        end else if (i_addr == REG_IRQ_ENABLE[ADDR_BITS-1:0]) begin
            read_mux[IRQ_W-1:0] = irq_enable;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= i_rd ? read_mux : '0;
        end
    end

endmodule : hall_commutation_decoder

// ### hall_commutation_decoder_asserts.sv
// Purpose: Pin level checks of the commutation decoder.
// Assumes: Two stage synchroniser; a pin reaches the drives in 3 edges.
// Notes: Hold windows of 4 samples match that latency exactly.
`timescale 1ns/1ps
module hall_commutation_decoder_asserts #(
    parameter int ADDR_BITS = 8,
    parameter int SYNC_DEPTH = 2
) (
    // Clock, reset and enable
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Pins
    input wire logic i_rotor_sensor_a,
    input wire logic i_rotor_sensor_b,
    input wire logic i_rotor_sensor_c,
    input wire logic i_phasing_jumper,
    input wire logic i_output_enable,
    input wire logic i_undervoltage,
    // Register port
    input wire logic [ADDR_BITS-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Outputs
    input wire logic [2:0] o_top_drive,
    input wire logic [2:0] o_bottom_drive,
    input wire logic o_fault_n,
    input wire logic o_irq
);
    import hall_commutation_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    wire logic [2:0] code = {i_rotor_sensor_a, i_rotor_sensor_b,
        i_rotor_sensor_c};
    wire logic bad = i_phasing_jumper ? (code == 3'h2 || code == 3'h5)
        : (code == 3'h0 || code == 3'h7);
    wire logic off = o_top_drive == 3'h0 && o_bottom_drive == 3'h0;
    a_one_top_bot: assert property (o_fault_n |-> $onehot(o_top_drive)
        && $onehot(o_bottom_drive) && (o_top_drive & o_bottom_drive) == 3'h0)
        else $error("drive pair not one top and one bottom leg");
    a_fault_tops_off: assert property (!o_fault_n |->
        o_top_drive == 3'h0) else $error("top drive on while fault low");
    a_enable_bottoms: assert property ((!i_output_enable && !bad &&
        !i_undervoltage && i_ce) [*4] |-> $onehot(o_bottom_drive))
        else $error("bottom drive lost with enable low");
    a_enable_fault: assert property ((!i_output_enable && i_ce) [*4]
        |-> !o_fault_n) else $error("fault high with enable low");
    a_invalid_off: assert property ((bad && i_ce) [*4]
        |-> off && !o_fault_n) else $error("invalid code left drives on");
    a_uv_all_off: assert property ((i_undervoltage && i_ce) [*4]
        |-> off && !o_fault_n) else $error("undervoltage left drives on");
    a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 32'h0)
        else $error("read data without a read");
    a_irq_masked: assert property (i_ce && i_wr && i_addr == REG_IRQ_ENABLE
        && i_wdata[3:0] == 4'h0 |=> !o_irq) else $error("irq while masked");
    c_fault_ends: cover property (!o_fault_n ##1 o_fault_n);
    c_irq_seen: cover property (o_irq);
    c_uv_held: cover property (i_undervoltage [*4]);
endmodule : hall_commutation_decoder_asserts
bind hall_commutation_decoder hall_commutation_decoder_asserts #(
    .ADDR_BITS(ADDR_BITS), .SYNC_DEPTH(SYNC_DEPTH)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_rotor_sensor_a(i_rotor_sensor_a), .i_rotor_sensor_b(i_rotor_sensor_b),
    .i_rotor_sensor_c(i_rotor_sensor_c), .i_phasing_jumper(i_phasing_jumper),
    .i_output_enable(i_output_enable), .i_undervoltage(i_undervoltage),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_top_drive(o_top_drive),
    .o_bottom_drive(o_bottom_drive), .o_fault_n(o_fault_n), .o_irq(o_irq));

// ### hall_commutation_decoder_tb_top.sv
// Purpose: Self-checking bench of the commutation decoder.
// Assumes: Clock enable stays high throughout.
// Notes: Drives are checked five edges after each pin change.
`timescale 1ns/1ps
module hall_commutation_decoder_tb_top;
    import hall_commutation_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, jmp = 1'b1, dir = 1'b1, oe = 1'b1;
    logic uv = 1'b0, wr_s = 1'b0, rd_s = 1'b0, stp = 1'b0, t120 = 1'b0;
    logic bwd = 1'b0, frc = 1'b0;
    logic [2:0] fcode = 3'h0, et, eb, code, top, bot;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic fault_n, irq;
    logic [15:0] inv_tab = 16'hA70D;
    int bad_count = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    hall_sensor_model hall_sensor_model_i (.i_ref_clk(clk), .i_rstn(rstn),
        .i_step(stp), .i_table120(t120), .i_backward(bwd), .i_force(frc),
        .i_force_code(fcode), .o_code(code));
    hall_commutation_decoder hall_commutation_decoder_i (.i_ref_clk(clk),
        .i_rstn(rstn), .i_ce(1'b1), .i_rotor_sensor_a(code[2]),
        .i_rotor_sensor_b(code[1]), .i_rotor_sensor_c(code[0]),
        .i_phasing_jumper(jmp), .i_direction(dir), .i_output_enable(oe),
        .i_undervoltage(uv), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
        .i_rd(rd_s), .o_rdata(rdata), .o_top_drive(top),
        .o_bottom_drive(bot), .o_fault_n(fault_n), .o_irq(irq));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 rv = rdata;
    endtask : rd
    task settle;
        repeat (5) @(posedge clk);
        #1;
    endtask : settle
    task expect_drive(input logic sel120, input logic fwd);
        logic [17:0] tab;
        logic [1:0] tl, bl;
        tab = sel120 ? CODES_120 : CODES_60;
        et = 3'h0;
        eb = 3'h0;
        for (int k = 0; k < POSITIONS; k++) begin
            if (tab[k * 3 +: 3] === code) begin
                tl = FWD_TOP_LEGS[k * 2 +: 2];
                bl = FWD_BOTTOM_LEGS[k * 2 +: 2];
                et = 3'h1 << (fwd ? tl : bl);
                eb = 3'h1 << (fwd ? bl : tl);
            end
        end
    endtask : expect_drive
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        #100000;
        bad_count++;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        settle;
        rd(REG_CONTROL);
        check(rv, {30'h0, CONTROL_RESET});
        rd(REG_IRQ_ENABLE);
        check(rv, 32'h0);
        rd(8'h1C);
        check(rv, 32'h0);
        wr(REG_IRQ_CLEAR, 32'hF);
        rd(REG_IRQ_STATUS);
        check(rv, 32'h0);
        $display("test registers done");
        for (int j = 0; j < 8; j++) begin
            @(posedge clk);
            {jmp, dir, bwd} <= j[2:0];
            t120 <= !j[2];
            repeat (6) begin
                @(posedge clk);
                stp <= 1'b1;
                @(posedge clk);
                stp <= 1'b0;
                settle;
                expect_drive(!jmp, dir);
                check(top, et);
                check(bot, eb);
                check(fault_n, 1'b1);
            end
        end
        $display("test commutation done");
        wr(REG_CONTROL, 32'h3);
        settle;
        expect_drive(!jmp, !dir);
        check({top, bot}, {et, eb});
        rd(REG_STATE);
        check({rv[ST_TOP_LSB +: 6], rv[ST_CODE_LSB +: 3]}, {eb, et, code});
        wr(REG_CONTROL, 32'h0);
        settle;
        expect_drive(!jmp, dir);
        check({fault_n, top, bot}, {4'h0, eb});
        wr(REG_CONTROL, 32'h1);
        $display("test control done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            frc <= 1'b1;
            {jmp, fcode} <= inv_tab[k * 4 +: 4];
            settle;
            check({fault_n, top, bot}, 7'h0);
        end
        @(posedge clk);
        {frc, oe} <= 2'h0;
        settle;
        expect_drive(!jmp, dir);
        check({fault_n, top, bot}, {4'h0, eb});
        $display("test invalid and enable done");
        @(posedge clk);
        oe <= 1'b1;
        wr(REG_IRQ_CLEAR, 32'hF);
        wr(REG_IRQ_ENABLE, 32'h8);
        @(posedge clk);
        uv <= 1'b1;
        settle;
        check({fault_n, top, bot}, 7'h0);
        check(irq, 1'b1);
        wr(REG_IRQ_CLEAR, 32'h8);
        rd(REG_IRQ_STATUS);
        check({irq, rv[IRQ_UNDERVOLT_BIT]}, 2'h0);
        wr(REG_IRQ_ENABLE, 32'h0);
        @(posedge clk);
        uv <= 1'b0;
        settle;
        @(posedge clk);
        uv <= 1'b1;
        settle;
        rd(REG_IRQ_STATUS);
        check({irq, rv[IRQ_UNDERVOLT_BIT]}, 2'h1);
        $display("test undervoltage done");
        stop_test;
    end
endmodule : hall_commutation_decoder_tb_top

// ### hall_commutation_pkg.sv
// Purpose: Shared constants for the Hall sensor commutation decoder.
// Assumes: Three phase legs A, B, C; six rotor positions per cycle.
// Notes: Code tables pack position 0 in the least significant bits.
package hall_commutation_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets, byte addresses.
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_STATE = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h0C;
    localparam logic [7:0] REG_IRQ_CLEAR = 8'h10;

    // Control register fields and reset value.
    localparam int CTRL_W = 2;
    localparam int CTRL_SOFT_ENABLE_BIT = 0;
    localparam int CTRL_DIR_INVERT_BIT = 1;
    localparam logic [1:0] CONTROL_RESET = 2'h1;

    // Interrupt bit positions, shared by status, enable and clear.
    localparam int IRQ_W = 4;
    localparam int IRQ_STEP_BIT = 0;
    localparam int IRQ_INVALID_BIT = 1;
    localparam int IRQ_FAULT_BIT = 2;
    localparam int IRQ_UNDERVOLT_BIT = 3;
    localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;

    // State register field positions.
    localparam int ST_CODE_LSB = 0;
    localparam int ST_INDEX_LSB = 3;
    localparam int ST_VALID_BIT = 6;
    localparam int ST_FAULT_BIT = 7;
    localparam int ST_TOP_LSB = 8;
    localparam int ST_BOTTOM_LSB = 11;
    localparam int ST_SEL120_BIT = 14;
    localparam int ST_FORWARD_BIT = 15;

    // Sensor code sequences (A is the most significant code bit).
    localparam int POSITIONS = 6;
    localparam logic [17:0] CODES_60 = 18'h017F4;
    localparam logic [17:0] CODES_120 = 18'h0B5A5;

    // Phase leg per forward position, two bits each: A=0, B=1, C=2.
    localparam logic [11:0] FWD_TOP_LEGS = 12'hA50;
    localparam logic [11:0] FWD_BOTTOM_LEGS = 12'h429;

    // Synchroniser depth for pin inputs.
    localparam int SYNC_STAGES = 2;

endpackage : hall_commutation_pkg

// ### hall_position_lookup.sv
// Purpose: Maps a three bit rotor sensor code to a position index.
// Assumes: Code is already synchronised; select chooses the table.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module hall_position_lookup (
    // Sensor code and table choice
    input wire logic [2:0] i_code,
    input wire logic i_sel_120,
    // Decoded position
    output logic o_valid,
    output logic [2:0] o_index
);
    import hall_commutation_pkg::*;

    logic [17:0] table_codes;
    logic [POSITIONS-1:0] match;

    assign table_codes = i_sel_120 ? CODES_120 : CODES_60; // (R7)

    genvar g;
    generate
        for (g = 0; g < POSITIONS; g++) begin : g_match
            assign match[g] = (i_code == table_codes[3*g +: 3]); // (R3) (R4)
        end
    endgenerate

    // A code appears at most once per table, so an OR of indices is safe.
    always_comb begin
        o_index = 3'h0;
        for (int k = 0; k < POSITIONS; k++) begin
            if (match[k]) begin
                o_index = o_index | k[2:0];
            end
        end
    end

    assign o_valid = |match; // (R9) (R13)

endmodule : hall_position_lookup

// ### hall_sensor_model.sv
// Purpose: Hall sensor set of a turning rotor, one step per 60 degrees.
// Assumes: Steps come from the bench as one cycle pulses.
// Notes: Backward travel mimics a 300 or 240 degree motor.
`timescale 1ns/1ps
module hall_sensor_model (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Motion and mode
    input wire logic i_step,
    input wire logic i_table120,
    input wire logic i_backward,
    input wire logic i_force,
    input wire logic [2:0] i_force_code,
    // Sensor lines
    output logic [2:0] o_code
);
    import hall_commutation_pkg::*;
    logic [2:0] pos;
    // Reverse order equals the mirrored phasing convention of the motor.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pos <= 3'h0;
        end else if (i_step) begin
            pos <= i_backward ? (pos == 3'h0 ? 3'h5 : pos - 3'h1)
                : (pos == 3'h5 ? 3'h0 : pos + 3'h1);
        end
    end
    assign o_code = i_force ? i_force_code : (i_table120 ?
        CODES_120[pos * 3 +: 3] : CODES_60[pos * 3 +: 3]);
endmodule : hall_sensor_model
